// ===== rtl/interrupt_vector_address_logic.sv
`timescale 1ns/1ns
module interrupt_vector_address_logic #(
	parameter bit FLASH_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [vector_pkg::ADDR_W-1:0] vectorTableBase,
	input wire logic globalEnable,
	input wire logic [vector_pkg::PRIO_W-1:0] processorPriorityLevel,
	input wire vector_pkg::prio_arr_t sourcePriorityField,
	input wire logic [vector_pkg::SLOT_CNT-1:0] srcReqA,
	input wire logic [vector_pkg::SLOT_CNT-1:0] srcReqB,
	input wire logic [vector_pkg::SLOT_CNT-1:0] srcSel,
	input wire logic [vector_pkg::SERIAL_CH_CNT-1:0] twoWireMode,
	input wire logic [vector_pkg::SERIAL_CH_CNT-1:0] nackEvent,
	input wire logic [vector_pkg::SERIAL_CH_CNT-1:0] ackEvent,
	input wire logic [vector_pkg::SLOT_CNT-1:0] pendClr,
	input wire logic [vector_pkg::FIX_CNT-1:0] fixSet,
	input wire logic coreReady,
	input wire vector_pkg::insn_req_s insnReq,
	input wire logic rdValid,
	input wire logic [vector_pkg::BYTE_W-1:0] rdData,
	input wire logic idChkReq,
	input wire logic [vector_pkg::ID_IDX_W-1:0] idChkIdx,
	output vector_pkg::mem_rd_s memRd,
	output vector_pkg::vec_out_s vecOut,
	output logic ackValid,
	output logic [vector_pkg::SLOT_W-1:0] ackSlot,
	output logic [vector_pkg::SLOT_CNT-1:0] requestPendingFlag,
	output logic [vector_pkg::BYTE_W-1:0] idChkData,
	output logic idChkDone,
	output logic busy
);
	import vector_pkg::*;

	state_s s_r;
	state_s s_nxt;
	logic [SLOT_CNT-1:0] slotReq;
	logic [SLOT_CNT-1:0] ackMask;
	logic [FIX_CNT-1:0] fixTaken;
	logic insnTaken;
	logic winValid;
	logic [SLOT_W-1:0] winSlot;

	// Relocatable slot address: base plus four times the number, wrapping in 20 bits
	function automatic logic [ADDR_W-1:0] relocAddr(input logic [ADDR_W-1:0] base,
		input logic [SW_NUM_W-1:0] num);
		relocAddr = base + ADDR_W'({num, 2'b00});
	endfunction

	// Top byte address of a fixed slot from its index, the undefined-opcode slot being index zero
	function automatic logic [ADDR_W-1:0] fixedHighByte(input logic [ID_IDX_W-1:0] idx);
		fixedHighByte = VEC_UNDEF_END + ADDR_W'({idx, 2'b00});
	endfunction

	// Source select per slot; only shared slots honour the select bit
	always_comb begin
		for (int i = 0; i < SLOT_CNT; i++) begin
			if (SHARED_SLOT_MASK[i] && srcSel[i]) begin
				slotReq[i] = srcReqB[i];
			end else begin
				slotReq[i] = srcReqA[i];
			end
		end
		// Two-wire mode turns serial tx/rx pairs into NACK/ACK events
		for (int c = 0; c < SERIAL_CH_CNT; c++) begin
			if (twoWireMode[c]) begin
				slotReq[SERIAL_PAIR_FIRST + 2 * c] = nackEvent[c];
				slotReq[SERIAL_PAIR_FIRST + 2 * c + 1] = ackEvent[c];
			end
		end
		slotReq[0] = 1'b0; // Slot zero is only reached by instruction
	end

	priority_arbiter #(
		.SLOTS(SLOT_CNT)
	) uArbiter (
		.pending(s_r.pend),
		.levels(sourcePriorityField),
		.globalEnable(globalEnable),
		.processorPriorityLevel(processorPriorityLevel),
		.winValid(winValid),
		.winSlot(winSlot)
	);

	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.vec.valid = 1'b0;
		s_nxt.ackValid = 1'b0;
		s_nxt.idDone = 1'b0;
		ackMask = '0;
		fixTaken = '0;
		insnTaken = 1'b0;
		case (s_r.fsm)
			ST_IDLE: begin
				if (s_r.boot) begin
					s_nxt.boot = 1'b0;
					s_nxt.slotAddr = VEC_RESET;
					s_nxt.kind = K_RESET;
					s_nxt.stackSave = 1'b0;
					s_nxt.fsm = ST_FETCH;
				end else if (coreReady && s_r.fix[FIX_NMI]) begin
					fixTaken[FIX_NMI] = 1'b1;
					s_nxt.slotAddr = VEC_NMI;
					s_nxt.kind = K_NMI;
					s_nxt.stackSave = 1'b0;
					s_nxt.fsm = ST_FETCH;
				end else if (coreReady && s_r.fix[FIX_DEBUG]) begin
					fixTaken[FIX_DEBUG] = 1'b1;
					s_nxt.slotAddr = VEC_DEBUG;
					s_nxt.kind = K_DEBUG;
					s_nxt.stackSave = 1'b0;
					s_nxt.fsm = ST_FETCH;
				end else if (coreReady && (s_r.fix[FIX_OSC] || s_r.fix[FIX_WDT])) begin
					fixTaken[FIX_OSC] = 1'b1;
					fixTaken[FIX_WDT] = 1'b1;
					s_nxt.slotAddr = VEC_OSC_WDT;
					s_nxt.kind = K_OSC_WDT;
					s_nxt.stackSave = 1'b0;
					s_nxt.fsm = ST_FETCH;
				end else if (coreReady && s_r.fix[FIX_STEP]) begin
					fixTaken[FIX_STEP] = 1'b1;
					s_nxt.slotAddr = VEC_SINGLE_STEP;
					s_nxt.kind = K_STEP;
					s_nxt.stackSave = 1'b0;
					s_nxt.fsm = ST_FETCH;
				end else if (coreReady && s_r.fix[FIX_ADDR]) begin
					fixTaken[FIX_ADDR] = 1'b1;
					s_nxt.slotAddr = VEC_ADDR_MATCH;
					s_nxt.kind = K_ADDR_MATCH;
					s_nxt.stackSave = 1'b0;
					s_nxt.fsm = ST_FETCH;
				end else if (coreReady && s_r.insn.req) begin
					insnTaken = 1'b1;
					s_nxt.stackSave = 1'b0;
					s_nxt.fsm = ST_FETCH;
					case (s_r.insn.kind)
						INSN_UNDEF: begin
							s_nxt.slotAddr = VEC_UNDEF;
							s_nxt.kind = K_UNDEF;
						end
						INSN_OVERFLOW: begin
							s_nxt.slotAddr = VEC_OVERFLOW;
							s_nxt.kind = K_OVERFLOW;
						end
						INSN_BREAK: begin
							s_nxt.slotAddr = BREAK_MARK_ADDR;
							s_nxt.kind = K_BREAK;
							s_nxt.fsm = ST_BRK_CHECK;
						end
						default: begin
							s_nxt.slotAddr = relocAddr(vectorTableBase, s_r.insn.num);
							s_nxt.kind = K_SWINT;
							s_nxt.stackSave = (s_r.insn.num < SW_KEEP_STACK_FIRST);
						end
					endcase
				end else if (coreReady && winValid) begin
					ackMask[winSlot] = 1'b1;
					s_nxt.ackValid = 1'b1;
					s_nxt.ackSlot = winSlot;
					s_nxt.slotAddr = relocAddr(vectorTableBase, {1'b0, winSlot});
					s_nxt.kind = K_PERIPH;
					s_nxt.stackSave = 1'b1;
					s_nxt.fsm = ST_FETCH;
				end else if (FLASH_VARIANT && idChkReq) begin
					s_nxt.slotAddr = fixedHighByte(idChkIdx);
					s_nxt.fsm = ST_ID_READ;
				end
				// Launch the first byte read of whatever was picked
				if (s_nxt.fsm != ST_IDLE) begin
					s_nxt.rd.req = 1'b1;
					s_nxt.rd.addr = s_nxt.slotAddr;
					s_nxt.byteIdx = 2'h0;
					s_nxt.target = '0;
				end
			end
			ST_BRK_CHECK: begin
				// Marker byte decides between relocatable slot zero and the fixed slot
				if (rdValid) begin
					if (rdData == BREAK_RELOC_MARK) begin
						s_nxt.slotAddr = relocAddr(vectorTableBase, SW_BREAK_NUM);
						s_nxt.stackSave = 1'b1;
					end else begin
						s_nxt.slotAddr = VEC_BREAK;
					end
					s_nxt.rd.addr = s_nxt.slotAddr;
					s_nxt.byteIdx = 2'h0;
					s_nxt.fsm = ST_FETCH;
				end
			end
			ST_FETCH: begin
				// Bytes come lowest address first, lowest byte least significant
				if (rdValid) begin
					s_nxt.target[{s_r.byteIdx, 3'b000} +: BYTE_W] = rdData;
					if (s_r.byteIdx == SLOT_LAST_BYTE) begin
						s_nxt.rd.req = 1'b0;
						s_nxt.vec.valid = 1'b1;
						s_nxt.vec.target = s_nxt.target;
						s_nxt.vec.slotAddr = s_r.slotAddr;
						s_nxt.vec.kind = s_r.kind;
						s_nxt.vec.stackSave = s_r.stackSave;
						s_nxt.fsm = ST_IDLE;
					end else begin
						s_nxt.byteIdx = s_r.byteIdx + 2'h1;
						s_nxt.rd.addr = s_r.slotAddr + ADDR_W'(s_nxt.byteIdx);
					end
				end
			end
			ST_ID_READ: begin
				if (rdValid) begin
					s_nxt.rd.req = 1'b0;
					s_nxt.idData = rdData;
					s_nxt.idDone = 1'b1;
					s_nxt.fsm = ST_IDLE;
				end
			end
			default: begin
				s_nxt.fsm = ST_IDLE;
				s_nxt.rd.req = 1'b0;
			end
		endcase
		// Flags: a new event in the clearing cycle wins over the clear
		s_nxt.pend = (s_r.pend & ~(pendClr | ackMask)) | slotReq;
		s_nxt.fix = (s_r.fix & ~fixTaken) | fixSet;
		if (insnReq.req) begin
			s_nxt.insn = insnReq;
		end else if (insnTaken) begin
			s_nxt.insn.req = 1'b0;
		end
		// Busy is registered so the port comes from a flip-flop
		s_nxt.busy = (s_nxt.fsm != ST_IDLE) || s_nxt.boot;
	end

	// State register; reset starts the reset vector fetch
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.fsm <= ST_IDLE;
			s_r.boot <= 1'b1;
			s_r.busy <= 1'b1;
			s_r.kind <= K_RESET;
			s_r.vec.kind <= K_RESET;
			s_r.insn.kind <= INSN_UNDEF;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign memRd = s_r.rd;
	assign vecOut = s_r.vec;
	assign ackValid = s_r.ackValid;
	assign ackSlot = s_r.ackSlot;
	assign requestPendingFlag = s_r.pend;
	assign idChkData = s_r.idData;
	assign idChkDone = s_r.idDone;
	assign busy = s_r.busy;

endmodule

// ===== rtl/priority_arbiter.sv
`timescale 1ns/1ns
module priority_arbiter #(
	parameter int SLOTS = 32
) (
	input wire logic [SLOTS-1:0] pending,
	input wire vector_pkg::prio_arr_t levels,
	input wire logic globalEnable,
	input wire logic [vector_pkg::PRIO_W-1:0] processorPriorityLevel,
	output logic winValid,
	output logic [vector_pkg::SLOT_W-1:0] winSlot
);
	import vector_pkg::*;

	logic [SLOTS-1:0] eligible;
	logic [PRIO_W-1:0] bestLevel;

	// Refuse slot counts the table cannot hold
	if (SLOTS < 2 || SLOTS > SLOT_CNT) begin : gBadSlots
		$error("priority_arbiter: SLOTS out of range");
	end

	// Per-slot eligibility: enable, request and level above the core level
	for (genvar i = 1; i < SLOTS; i++) begin : gElig
		assign eligible[i] = globalEnable && pending[i] && (levels[i] > processorPriorityLevel);
	end
	assign eligible[0] = 1'b0;

	// Highest level wins, lowest slot number breaks ties
	always_comb begin
		winValid = 1'b0;
		winSlot = SLOT_ZERO;
		bestLevel = '0;
		for (int i = 1; i < SLOTS; i++) begin
			if (eligible[i] && (!winValid || levels[i] > bestLevel)) begin
				winValid = 1'b1;
				winSlot = SLOT_W'(i);
				bestLevel = levels[i];
			end
		end
	end

endmodule

// ===== rtl/vector_pkg.sv
package vector_pkg;

	// Widths
	localparam int ADDR_W = 20;
	localparam int TARGET_W = 32;
	localparam int BYTE_W = 8;
	localparam int PRIO_W = 3;
	localparam int SW_NUM_W = 6;
	localparam int SLOT_CNT = 32;
	localparam int SLOT_W = 5;
	localparam int ID_IDX_W = 3;

	// Fixed vector slots, four bytes each, ascending to the top of memory
	localparam logic [ADDR_W-1:0] VEC_UNDEF = 20'hFFFDC;
	localparam logic [ADDR_W-1:0] VEC_UNDEF_END = 20'hFFFDF;
	localparam logic [ADDR_W-1:0] VEC_OVERFLOW = 20'hFFFE0;
	localparam logic [ADDR_W-1:0] VEC_BREAK = 20'hFFFE4;
	localparam logic [ADDR_W-1:0] VEC_ADDR_MATCH = 20'hFFFE8;
	localparam logic [ADDR_W-1:0] VEC_SINGLE_STEP = 20'hFFFEC;
	localparam logic [ADDR_W-1:0] VEC_OSC_WDT = 20'hFFFF0;
	localparam logic [ADDR_W-1:0] VEC_DEBUG = 20'hFFFF4;
	localparam logic [ADDR_W-1:0] VEC_NMI = 20'hFFFF8;
	localparam logic [ADDR_W-1:0] VEC_RESET = 20'hFFFFC;

	// Break relocation marker byte
	localparam logic [ADDR_W-1:0] BREAK_MARK_ADDR = 20'hFFFE7;
	localparam logic [BYTE_W-1:0] BREAK_RELOC_MARK = 8'hFF;

	// Slot geometry
	localparam int SLOT_BYTES = 4;
	localparam int TABLE_BYTES = 256;
	localparam logic [1:0] SLOT_LAST_BYTE = 2'h3;
	localparam logic [SW_NUM_W-1:0] SW_KEEP_STACK_FIRST = 6'h20;
	localparam logic [SW_NUM_W-1:0] SW_BREAK_NUM = 6'h00;

	// Relocatable slots shared by two sources (5..9, 14, 23, 24, 26, 27)
	localparam logic [SLOT_CNT-1:0] SHARED_SLOT_MASK = 32'h0D8043E0;
	localparam int SERIAL_PAIR_FIRST = 15;
	localparam int SERIAL_CH_CNT = 3;

	// Fixed hardware event flag positions
	localparam int FIX_NMI = 0;
	localparam int FIX_DEBUG = 1;
	localparam int FIX_OSC = 2;
	localparam int FIX_WDT = 3;
	localparam int FIX_STEP = 4;
	localparam int FIX_ADDR = 5;
	localparam int FIX_CNT = 6;

	typedef logic [SLOT_CNT-1:0][PRIO_W-1:0] prio_arr_t;

	typedef enum logic [1:0] {INSN_UNDEF, INSN_OVERFLOW, INSN_BREAK, INSN_SWINT} insn_e;

	typedef enum logic [1:0] {ST_IDLE, ST_BRK_CHECK, ST_FETCH, ST_ID_READ} fsm_e;

	typedef enum logic [3:0] {
		K_RESET, K_NMI, K_DEBUG, K_OSC_WDT, K_STEP, K_ADDR_MATCH,
		K_UNDEF, K_OVERFLOW, K_BREAK, K_SWINT, K_PERIPH
	} kind_e;

	typedef struct packed {
		logic req;
		insn_e kind;
		logic [SW_NUM_W-1:0] num;
	} insn_req_s;

	typedef struct packed {
		logic req;
		logic [ADDR_W-1:0] addr;
	} mem_rd_s;

	typedef struct packed {
		logic valid;
		logic [TARGET_W-1:0] target;
		logic [ADDR_W-1:0] slotAddr;
		kind_e kind;
		logic stackSave;
	} vec_out_s;

	typedef struct packed {
		fsm_e fsm;
		logic boot;
		insn_req_s insn;
		logic [SLOT_CNT-1:0] pend;
		logic [FIX_CNT-1:0] fix;
		mem_rd_s rd;
		logic [1:0] byteIdx;
		logic [ADDR_W-1:0] slotAddr;
		logic [TARGET_W-1:0] target;
		kind_e kind;
		logic stackSave;
		vec_out_s vec;
		logic ackValid;
		logic [SLOT_W-1:0] ackSlot;
		logic [BYTE_W-1:0] idData;
		logic idDone;
		logic busy;
	} state_s;

	localparam logic [SLOT_W-1:0] SLOT_ZERO = 5'h00;

endpackage

// ===== verification/tb.sv
`timescale 1ns/1ns
module tb;
	import vector_pkg::*;
	logic clk, sys_rst, globalEnable, coreReady, rdValid, idChkReq, markFF, ackValid, idChkDone, busy;
	logic [ADDR_W-1:0] vectorTableBase;
	logic [PRIO_W-1:0] processorPriorityLevel;
	prio_arr_t sourcePriorityField;
	logic [SLOT_CNT-1:0] srcReqA, srcReqB, srcSel, pendClr, requestPendingFlag;
	logic [2:0] twoWireMode, nackEvent, ackEvent, idChkIdx;
	logic [FIX_CNT-1:0] fixSet;
	insn_req_s insnReq;
	logic [7:0] rdData, idChkData;
	mem_rd_s memRd;
	vec_out_s vecOut;
	logic [SLOT_W-1:0] ackSlot, lastAck;
	int err_total, comparisons, cyc, ackCnt;
	localparam logic [ADDR_W-1:0] FIXA [6] = '{VEC_NMI, VEC_DEBUG, VEC_OSC_WDT, VEC_OSC_WDT, VEC_SINGLE_STEP,
		VEC_ADDR_MATCH};
	localparam kind_e FIXK [6] = '{K_NMI, K_DEBUG, K_OSC_WDT, K_OSC_WDT, K_STEP, K_ADDR_MATCH};
	interrupt_vector_address_logic DUT (.clk, .sys_rst, .vectorTableBase, .globalEnable, .processorPriorityLevel,
		.sourcePriorityField, .srcReqA, .srcReqB, .srcSel, .twoWireMode, .nackEvent, .ackEvent, .pendClr, .fixSet,
		.coreReady, .insnReq, .rdValid, .rdData, .idChkReq, .idChkIdx, .memRd, .vecOut, .ackValid, .ackSlot,
		.requestPendingFlag, .idChkData, .idChkDone, .busy);
	vec_memory_model mem (.clk, .memRd, .markFF, .rdValid, .rdData);
	// Clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Accepted slots and hang limit
	always @(posedge clk) begin
		cyc++;
		if (ackValid === 1'b1) begin
			lastAck <= ackSlot;
			ackCnt++;
		end
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	function automatic logic [7:0] mb(input logic [19:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction
	function automatic logic [31:0] tgt(input logic [19:0] a);
		return {mb(a + 20'h3), mb(a + 20'h2), mb(a + 20'h1), mb(a)};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic waitVec(input logic [19:0] a, input kind_e k, input logic s);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (vecOut.valid !== 1'b1 && n < 300);
		chk(32'(vecOut.valid), 32'h1);
		chk(32'(vecOut.slotAddr), 32'(a));
		chk(vecOut.target, tgt(a));
		chk(32'(vecOut.kind), 32'(k));
		chk(32'(vecOut.stackSave), 32'(s));
	endtask
	task automatic insnGo(input insn_e k, input logic [5:0] n);
		@(posedge clk);
		insnReq <= '{1'b1, k, n};
		@(posedge clk);
		insnReq <= '0;
	endtask
	task automatic periph(input int s, input logic useB);
		@(posedge clk);
		srcSel <= 32'(useB) << s;
		if (useB) srcReqB <= 32'h1 << s;
		else srcReqA <= 32'h1 << s;
		@(posedge clk);
		srcReqA <= '0;
		srcReqB <= '0;
		waitVec(vectorTableBase + 20'(4 * s), K_PERIPH, 1'b1);
		chk(32'(lastAck), 32'(s));
		chk(32'(requestPendingFlag[s]), 32'h0);
	endtask
	task automatic endTest(input string name);
		$display("test %s done, mismatches %0d", name, err_total);
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		int s;
		logic [5:0] n;
		void'($urandom(32'hE5CB6BDC));
		{sys_rst, globalEnable, coreReady} = 3'b111;
		vectorTableBase = 20'($urandom) & 20'hFFFFE;
		processorPriorityLevel = 3'h0;
		sourcePriorityField = {SLOT_CNT{3'h4}};
		{srcReqA, srcReqB, srcSel, pendClr} = '0;
		{twoWireMode, nackEvent, ackEvent, idChkIdx, fixSet, idChkReq, markFF} = '0;
		insnReq = '0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		waitVec(VEC_RESET, K_RESET, 1'b0);
		endTest("reset");
		for (int i = 0; i < FIX_CNT; i++) begin
			@(posedge clk);
			fixSet <= 6'(1 << i);
			@(posedge clk);
			fixSet <= '0;
			waitVec(FIXA[i], FIXK[i], 1'b0);
		end
		endTest("fixed");
		insnGo(INSN_UNDEF, 6'h0);
		waitVec(VEC_UNDEF, K_UNDEF, 1'b0);
		insnGo(INSN_OVERFLOW, 6'h0);
		waitVec(VEC_OVERFLOW, K_OVERFLOW, 1'b0);
		insnGo(INSN_BREAK, 6'h0);
		waitVec(VEC_BREAK, K_BREAK, 1'b0);
		markFF = 1'b1;
		insnGo(INSN_BREAK, 6'h0);
		waitVec(vectorTableBase, K_BREAK, 1'b1);
		markFF = 1'b0;
		for (int i = 0; i < 8; i++) begin
			n = (i < 4) ? 6'(i * 21) : 6'($urandom);
			insnGo(INSN_SWINT, n);
			waitVec(vectorTableBase + 20'(4 * n), K_SWINT, n < 6'h20);
		end
		endTest("instructions");
		foreach (FIXK[i]) periph(FIXA[i] == VEC_NMI ? 6 : i + 5, 1'b0);
		foreach (FIXK[i]) periph(i < 2 ? i + 6 : (i == 2 ? 14 : (i == 3 ? 23 : i + 22)), i[0]);
		repeat (6) begin
			s = 1 + $urandom_range(30);
			periph(s, SHARED_SLOT_MASK[s] & 1'($urandom));
		end
		endTest("peripheral");
		// Masked request: flag sets, nothing is accepted, software clears it
		globalEnable <= 1'b0;
		@(posedge clk);
		srcReqA <= 32'h1 << 11;
		@(posedge clk);
		srcReqA <= '0;
		ackCnt = 0;
		repeat (20) @(posedge clk);
		chk(32'(ackCnt), 32'h0);
		chk(32'(requestPendingFlag[11]), 32'h1);
		pendClr <= 32'h1 << 11;
		@(posedge clk);
		pendClr <= '0;
		globalEnable <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		chk(32'(requestPendingFlag[11]), 32'h0);
		endTest("masked");
		twoWireMode <= 3'b111;
		for (int c = 0; c < SERIAL_CH_CNT; c++) begin
			@(posedge clk);
			nackEvent <= 3'(1 << c);
			@(posedge clk);
			nackEvent <= '0;
			waitVec(vectorTableBase + 20'(60 + 8 * c), K_PERIPH, 1'b1);
			@(posedge clk);
			ackEvent <= 3'(1 << c);
			@(posedge clk);
			ackEvent <= '0;
			waitVec(vectorTableBase + 20'(64 + 8 * c), K_PERIPH, 1'b1);
		end
		endTest("two wire");
		repeat (3) begin
			s = $urandom_range(7);
			@(posedge clk);
			idChkReq <= 1'b1;
			idChkIdx <= 3'(s);
			@(posedge clk);
			idChkReq <= 1'b0;
			repeat (100) if (idChkDone !== 1'b1) @(posedge clk);
			chk(32'(idChkData), 32'(mb(VEC_UNDEF_END + 20'(4 * s))));
		end
		endTest("id check");
		summarize();
	end
endmodule

// ===== verification/vec_checker.sv
`timescale 1ns/1ns
module vec_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic globalEnable,
	input wire logic [vector_pkg::PRIO_W-1:0] processorPriorityLevel,
	input wire vector_pkg::prio_arr_t sourcePriorityField,
	input wire logic [vector_pkg::SLOT_CNT-1:0] srcReqA,
	input wire logic rdValid,
	input wire vector_pkg::mem_rd_s memRd,
	input wire vector_pkg::vec_out_s vecOut,
	input wire logic ackValid,
	input wire logic [vector_pkg::SLOT_W-1:0] ackSlot,
	input wire logic [vector_pkg::SLOT_CNT-1:0] requestPendingFlag,
	input wire logic busy
);
	import vector_pkg::*;
	logic rst_r;
	logic ge_r;
	logic [PRIO_W-1:0] ipl_r;
	prio_arr_t lvl_r;
	logic [SLOT_CNT-1:0] pend_r;
	// Acceptance inputs as the design saw them one edge ago
	always_ff @(posedge clk) begin
		rst_r <= sys_rst;
		ge_r <= globalEnable;
		ipl_r <= processorPriorityLevel;
		lvl_r <= sourcePriorityField;
		pend_r <= requestPendingFlag;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// One byte handed over by memory
	sequence sByte;
		memRd.req && rdValid;
	endsequence
	AST_RESET_FETCH: assert property (rst_r |=> memRd.req && memRd.addr == VEC_RESET)
		else $error("reset fetch missing");
	AST_ADDR_STANDS: assert property (memRd.req && !rdValid |=> memRd.req && $stable(memRd.addr))
		else $error("read address moved");
	AST_BYTE_STEP: assert property (sByte ##0 memRd.addr[1:0] != 2'h3 ##1 memRd.req |-> memRd.addr == $past(memRd.addr) + 20'h1)
		else $error("bytes not ascending");
	AST_VALID_ONE: assert property (vecOut.valid |=> !vecOut.valid)
		else $error("vector valid too long");
	AST_VALID_CAUSE: assert property (vecOut.valid |-> $past(rdValid && memRd.req)
		&& $past(memRd.addr) == vecOut.slotAddr + 20'h3)
		else $error("vector not after fourth byte");
	AST_OSC_SLOT: assert property (vecOut.valid && vecOut.kind == K_OSC_WDT |-> vecOut.slotAddr == VEC_OSC_WDT)
		else $error("shared fixed slot wrong");
	AST_NMI_SLOT: assert property (vecOut.valid && vecOut.kind == K_NMI |-> vecOut.slotAddr == VEC_NMI)
		else $error("nmi slot wrong");
	AST_ACK_GATE: assert property (ackValid |-> ge_r && pend_r[ackSlot] && lvl_r[ackSlot] > ipl_r)
		else $error("accept without condition");
	AST_FLAG_SET: assert property (srcReqA[11] |=> requestPendingFlag[11])
		else $error("flag not set");
	AST_PERIPH_STACK: assert property (vecOut.valid && vecOut.kind == K_PERIPH |-> vecOut.stackSave)
		else $error("stack save missing");
	AST_BUSY: assert property (memRd.req |-> busy)
		else $error("busy low in fetch");
endmodule
bind interrupt_vector_address_logic vec_checker chk (.clk, .sys_rst, .globalEnable, .processorPriorityLevel,
	.sourcePriorityField, .srcReqA, .rdValid, .memRd, .vecOut, .ackValid, .ackSlot, .requestPendingFlag, .busy);

// ===== verification/vec_memory_model.sv
`timescale 1ns/1ns
module vec_memory_model (
	input wire logic clk,
	input wire vector_pkg::mem_rd_s memRd,
	input wire logic markFF,
	output logic rdValid,
	output logic [vector_pkg::BYTE_W-1:0] rdData
);
	import vector_pkg::*;
	logic [1:0] waitCnt;
	initial begin
		rdValid = 1'b0;
		rdData = 8'h00;
		waitCnt = 2'h0;
	end
	// One byte per request, at once or after a stall; data inverts in the cycle after each byte
	always @(posedge clk) begin
		if (rdValid) begin
			rdValid <= 1'b0;
			rdData <= ~rdData;
		end else if (memRd.req) begin
			if (waitCnt == 2'h0) begin
				rdValid <= 1'b1;
				rdData <= (markFF && memRd.addr == BREAK_MARK_ADDR) ? BREAK_RELOC_MARK : memRd.addr[7:0] ^ 8'h5A;
				waitCnt <= 2'($urandom_range(2));
			end else begin
				waitCnt <= waitCnt - 2'h1;
			end
		end
	end
endmodule
